// ### verilog/wdg_regs.svh
// register map, field positions, reset values and timing counts of the windowed watchdog
// assumes a 4-bit byte address and 16-bit data on the register port
`ifndef WDG_REGS_SVH
`define WDG_REGS_SVH

`define WDG_ADDR_REFRESH    4'h0
`define WDG_ADDR_CONTROL    4'h2
`define WDG_ADDR_STATUS     4'h4
`define WDG_ADDR_ACTION     4'h6
`define WDG_ADDR_STOP       4'h8

`define WDG_CTL_TOPS_LSB    0
`define WDG_CTL_CKS_LSB     4
`define WDG_CTL_RPES_LSB    8
`define WDG_CTL_RPSS_LSB    12
`define WDG_ACT_RSTSEL_BIT  7
`define WDG_STOP_BIT        7
`define WDG_STAT_UNDERFLOW_FLAG_BIT   14
`define WDG_STAT_REFRESH_ERROR_FLAG_BIT  15

`define WDG_BOOT_TOPS_LSB   0
`define WDG_BOOT_CKS_LSB    4
`define WDG_BOOT_RPES_LSB   8
`define WDG_BOOT_RPSS_LSB   12
`define WDG_BOOT_RSTSEL_BIT 14
`define WDG_BOOT_STOP_BIT   15

`define WDG_CONTROL_RESET   16'h33F3
`define WDG_ACTION_RESET    1'h1
`define WDG_STOP_RESET      1'h0

`define WDG_KEY_ARM         8'h00
`define WDG_KEY_FIRE        8'hFF

`define WDG_RELOAD_1K       14'h03FF
`define WDG_RELOAD_4K       14'h0FFF
`define WDG_RELOAD_8K       14'h1FFF
`define WDG_RELOAD_16K      14'h3FFF

`define WDG_RESET_PULSE_TICKS 1

`endif

// ### verilog/wdg_pkg.sv
// types shared by the windowed watchdog
// no assumptions beyond the register header
package wdg_pkg;

  typedef struct packed {
    logic [3:0] cks;
    logic [1:0] tops;
    logic [1:0] rpss;
    logic [1:0] rpes;
    logic       rst_sel;
    logic       stop;
  } wdg_cfg_t;

  typedef enum logic [1:0] {
    ST_WAIT_BOOT,
    ST_IDLE,
    ST_COUNT,
    ST_RESET
  } wdg_state_t;

endpackage

// ### verilog/wdg_windowed_watchdog.sv
// windowed down-counting watchdog with boot-word or register start
// assumes clk 40 MHz, watchdog_clock slower and synchronous to clk, strobes one cycle
//
// Behaviour
// - start mode bit picks registers or boot word
// - auto mode counts from boot reload after reset
// - first refresh loads control reload, starts counting
// - in-window refresh reloads, counting continues
// - underflow or window error: reset or nmi
// - config registers writable once before first refresh
// - write protect cleared by block reset or, in register mode, own reset
// - refresh is 00h then FFh write
// - non-00h, non-FFh write after 00h disarms the sequence
// - repeated 00h stays armed; prior junk harmless
// - reads and other accesses keep arming
// - only FFh write timing checked against window
// - refresh applied at the next count cycle
// - status shows 14-bit counter value
// - sticky cause flags survive watchdog reset
// - write 0 clears flag, 1 ignored
// - new event replaces earlier recorded cause
// - flag clear visible within bounded delay
// - period 1k/4k/8k/16k, divider 1..256
// - window start/end quarters; end>start ignored
// - reset one count cycle; restart per mode
// - count stop in low power when enabled
`timescale 1ns/1ps
`include "wdg_regs.svh"

module wdg_windowed_watchdog #(
  parameter int COUNT_WIDTH    = 14,
  parameter int PRESCALE_WIDTH = 8
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        watchdog_clock,
  input  wire logic        low_power_entry,
  input  wire logic        start_mode_select,
  input  wire logic [15:0] boot_option_word,
  input  wire logic [3:0]  bus_addr,
  input  wire logic [15:0] bus_wdata,
  input  wire logic        bus_write,
  input  wire logic        bus_read,
  output logic      [15:0] bus_rdata,
  output logic             watchdog_reset_out,
  output logic             watchdog_nmi_request
);

  // refuse parameters the logic cannot serve
  if (COUNT_WIDTH != 14 || PRESCALE_WIDTH < 8)
  begin
    $error("watchdog needs a 14-bit counter and an 8-bit prescaler");
  end

  // control reset word, sliced per field below
  localparam logic [15:0] CONTROL_RESET = `WDG_CONTROL_RESET;

  // reset release through two flops
  logic rst_q1;
  logic rst_n;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // divider selection to prescaler mask
  function automatic logic [7:0] div_mask(input logic [3:0] cks);
    case (cks)
      4'h0:    div_mask = 8'h00;
      4'h2:    div_mask = 8'h0F;
      4'h3:    div_mask = 8'h1F;
      4'h4:    div_mask = 8'h3F;
      4'hF:    div_mask = 8'h7F;
      4'h5:    div_mask = 8'hFF;
      default: div_mask = 8'h00;
    endcase
  endfunction

  // time-out period to reload value
  function automatic logic [13:0] reload_of(input logic [1:0] tops);
    case (tops)
      2'h0:    reload_of = `WDG_RELOAD_1K;
      2'h1:    reload_of = `WDG_RELOAD_4K;
      2'h2:    reload_of = `WDG_RELOAD_8K;
      default: reload_of = `WDG_RELOAD_16K;
    endcase
  endfunction

  // counter value at n quarters of the period
  function automatic logic [13:0] quarter_val(input logic [1:0] tops, input logic [2:0] n);
    logic [13:0] q;
    logic [16:0] p;
    q = 14'((reload_of(tops) >> 2) + 14'h0001);
    p = 17'(17'(q) * 17'(n));
    quarter_val = 14'(p - 17'h00001);
  endfunction

  // boot word capture after reset release
  logic               boot_taken;
  logic               reg_mode;
  wdg_pkg::wdg_cfg_t  boot_cfg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      boot_taken <= 1'b0;
      reg_mode   <= 1'b0;
      boot_cfg   <= '0;
    end
    else if (!boot_taken)
    begin
      boot_taken       <= 1'b1;
      reg_mode         <= start_mode_select;
      boot_cfg.tops    <= boot_option_word[`WDG_BOOT_TOPS_LSB +: 2];
      boot_cfg.cks     <= boot_option_word[`WDG_BOOT_CKS_LSB +: 4];
      boot_cfg.rpes    <= boot_option_word[`WDG_BOOT_RPES_LSB +: 2];
      boot_cfg.rpss    <= boot_option_word[`WDG_BOOT_RPSS_LSB +: 2];
      boot_cfg.rst_sel <= boot_option_word[`WDG_BOOT_RSTSEL_BIT];
      boot_cfg.stop    <= boot_option_word[`WDG_BOOT_STOP_BIT];
    end
  end

  // register side configuration
  wdg_pkg::wdg_cfg_t  reg_cfg;
  wdg_pkg::wdg_cfg_t  act;
  logic               protect;
  logic               cfg_write;
  logic               ref_write;
  logic               ref_fire;
  logic               armed;
  wdg_pkg::wdg_state_t state;

  assign act = reg_mode ? reg_cfg : boot_cfg;

  assign ref_write = bus_write && bus_addr == `WDG_ADDR_REFRESH;
  assign cfg_write = bus_write && !protect && (bus_addr == `WDG_ADDR_CONTROL ||
                     bus_addr == `WDG_ADDR_ACTION || bus_addr == `WDG_ADDR_STOP);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_cfg.tops    <= CONTROL_RESET[`WDG_CTL_TOPS_LSB +: 2];
      reg_cfg.cks     <= CONTROL_RESET[`WDG_CTL_CKS_LSB +: 4];
      reg_cfg.rpes    <= CONTROL_RESET[`WDG_CTL_RPES_LSB +: 2];
      reg_cfg.rpss    <= CONTROL_RESET[`WDG_CTL_RPSS_LSB +: 2];
      reg_cfg.rst_sel <= `WDG_ACTION_RESET;
      reg_cfg.stop    <= `WDG_STOP_RESET;
    end
    else if (cfg_write)
    begin
      case (bus_addr)
        `WDG_ADDR_CONTROL:
        begin
          reg_cfg.tops <= bus_wdata[`WDG_CTL_TOPS_LSB +: 2];
          reg_cfg.cks  <= bus_wdata[`WDG_CTL_CKS_LSB +: 4];
          reg_cfg.rpes <= bus_wdata[`WDG_CTL_RPES_LSB +: 2];
          reg_cfg.rpss <= bus_wdata[`WDG_CTL_RPSS_LSB +: 2];
        end
        `WDG_ADDR_ACTION:
          reg_cfg.rst_sel <= bus_wdata[`WDG_ACT_RSTSEL_BIT];
        default:
          reg_cfg.stop <= bus_wdata[`WDG_STOP_BIT];
      endcase
    end
  end

  // write protection
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      protect <= 1'b0;
    else if (state == wdg_pkg::ST_RESET && reg_mode)
      protect <= 1'b0;
    // any config write or refresh locks
    else if (cfg_write || ref_fire)
      protect <= 1'b1;
  end

  // refresh key sequence
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      armed <= 1'b0;
    // only refresh writes touch the arm
    else if (ref_write)
    begin
      armed <= bus_wdata[7:0] == `WDG_KEY_ARM;
    end
  end

  assign ref_fire = ref_write && armed && bus_wdata[7:0] == `WDG_KEY_FIRE;

  // count tick from watchdog clock
  logic                      wclk_q;
  logic                      wclk_q2;
  logic [PRESCALE_WIDTH-1:0] prescale;
  logic                      wclk_edge;
  logic                      tick;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wclk_q  <= 1'b0;
      wclk_q2 <= 1'b0;
    end
    else
    begin
      wclk_q  <= watchdog_clock;
      wclk_q2 <= wclk_q;
    end
  end

  assign wclk_edge = wclk_q && !wclk_q2;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prescale <= '0;
    else if (wclk_edge)
      prescale <= prescale + 1'b1;
  end

  // one count cycle per divided watchdog clock
  assign tick = wclk_edge && ((prescale[7:0] & div_mask(act.cks)) == div_mask(act.cks));

  // window decode
  logic [13:0] cnt;
  logic [2:0]  start_n;
  logic [2:0]  end_n;
  logic [13:0] start_val;
  logic [13:0] end_val;
  logic        in_window;
  logic        halted;
  logic        pend_refresh;
  logic        err_event;
  logic        uf_event;

  assign start_n   = 3'(act.rpss) + 3'h1;
  assign end_n     = 3'h3 - 3'(act.rpes);
  assign start_val = quarter_val(act.tops, start_n);
  assign end_val   = quarter_val(act.tops, end_n);

  // end ignored when zero or above start
  assign in_window = cnt <= start_val &&
                     (end_n == 3'h0 || end_n > start_n || cnt >= end_val);

  assign halted = act.stop && low_power_entry;

  // checked only at the FFh write
  assign err_event = ref_fire && state == wdg_pkg::ST_COUNT && !in_window;
  assign uf_event  = tick && state == wdg_pkg::ST_COUNT && !err_event &&
                     !pend_refresh && !halted && cnt == 14'h0000;

  // refresh waits for next count tick
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pend_refresh <= 1'b0;
    else if (err_event || uf_event || state == wdg_pkg::ST_RESET)
      pend_refresh <= 1'b0;
    else if (ref_fire)
      pend_refresh <= 1'b1;
    else if (tick)
      pend_refresh <= 1'b0;
  end

  // counter and mode sequence
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= wdg_pkg::ST_WAIT_BOOT;
      cnt   <= '0;
    end
    else
    begin
      case (state)
        wdg_pkg::ST_WAIT_BOOT:
        begin
          if (boot_taken)
          begin
            if (reg_mode)
              state <= wdg_pkg::ST_IDLE;
            else
            begin
              state <= wdg_pkg::ST_COUNT;
              cnt   <= reload_of(act.tops);
            end
          end
        end
        wdg_pkg::ST_IDLE:
        begin
          if (tick && pend_refresh)
          begin
            state <= wdg_pkg::ST_COUNT;
            cnt   <= reload_of(act.tops);
          end
        end
        wdg_pkg::ST_COUNT:
        begin
          if (err_event || uf_event)
          begin
            if (act.rst_sel)
            begin
              state <= wdg_pkg::ST_RESET;
              if (reg_mode)
                cnt <= '0;
            end
            else
              cnt <= reload_of(act.tops);
          end
          else if (tick && pend_refresh)
            cnt <= reload_of(act.tops);
          else if (tick && !halted)
            cnt <= cnt - 14'h0001;
        end
        wdg_pkg::ST_RESET:
        begin
          // one count cycle, then restart or hold
          if (tick)
          begin
            if (reg_mode)
            begin
              state <= wdg_pkg::ST_IDLE;
              cnt   <= '0;
            end
            else
            begin
              state <= wdg_pkg::ST_COUNT;
              cnt   <= reload_of(act.tops);
            end
          end
        end
        default:
          state <= wdg_pkg::ST_WAIT_BOOT;
      endcase
    end
  end

  assign watchdog_reset_out = state == wdg_pkg::ST_RESET;

  // nmi pulse
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      watchdog_nmi_request <= 1'b0;
    else
      watchdog_nmi_request <= (err_event || uf_event) && !act.rst_sel;
  end

  // cause flags
  logic underflow_flag;
  logic refresh_error_flag;
  logic stat_write;

  assign stat_write = bus_write && bus_addr == `WDG_ADDR_STATUS;

  // block reset, a zero write or the other cause clears them; watchdog reset does not
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      underflow_flag  <= 1'b0;
      refresh_error_flag <= 1'b0;
    end
    // new cause replaces old; set beats clear
    else if (err_event)
    begin
      refresh_error_flag <= 1'b1;
      underflow_flag  <= 1'b0;
    end
    else if (uf_event)
    begin
      underflow_flag  <= 1'b1;
      refresh_error_flag <= 1'b0;
    end
    // zero clears on the next edge
    else if (stat_write)
    begin
      underflow_flag  <= underflow_flag && bus_wdata[`WDG_STAT_UNDERFLOW_FLAG_BIT];
      refresh_error_flag <= refresh_error_flag && bus_wdata[`WDG_STAT_REFRESH_ERROR_FLAG_BIT];
    end
  end

  // read data one cycle after the strobe
  logic [15:0] read_mux;

  always_comb
  begin
    read_mux = 16'h0000;
    case (bus_addr)
      `WDG_ADDR_CONTROL:
      begin
        read_mux[`WDG_CTL_TOPS_LSB +: 2] = reg_cfg.tops;
        read_mux[`WDG_CTL_CKS_LSB +: 4]  = reg_cfg.cks;
        read_mux[`WDG_CTL_RPES_LSB +: 2] = reg_cfg.rpes;
        read_mux[`WDG_CTL_RPSS_LSB +: 2] = reg_cfg.rpss;
      end
      `WDG_ADDR_STATUS:
      begin
        read_mux[13:0]                = cnt;
        read_mux[`WDG_STAT_UNDERFLOW_FLAG_BIT]  = underflow_flag;
        read_mux[`WDG_STAT_REFRESH_ERROR_FLAG_BIT] = refresh_error_flag;
      end
      `WDG_ADDR_ACTION:
        read_mux[`WDG_ACT_RSTSEL_BIT] = reg_cfg.rst_sel;
      `WDG_ADDR_STOP:
        read_mux[`WDG_STOP_BIT] = reg_cfg.stop;
      default:
        read_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bus_rdata <= 16'h0000;
    else if (bus_read)
      bus_rdata <= read_mux;
    else
      bus_rdata <= 16'h0000;
  end

endmodule

// ### verif/wdg_host_model.sv
// host side model: watchdog count clock source and system event counters
// assumes clk is the bus clock; count clock is clk divided by four
`timescale 1ns/1ps

module wdg_host_model (
  input  wire logic       clk,
  input  wire logic       watchdog_reset_out,
  input  wire logic       watchdog_nmi_request,
  output logic            watchdog_clock,
  output logic      [7:0] reset_count,
  output logic      [7:0] nmi_count
);
  logic [1:0] div = 2'h0;
  logic       prev_rst = 1'b0;

  always_ff @(posedge clk)
  begin
    div <= div + 2'h1;
  end
  assign watchdog_clock = div[1];

  always @(posedge clk)
  begin
    prev_rst <= watchdog_reset_out;
    if (watchdog_reset_out && !prev_rst)
      reset_count <= reset_count + 8'h01;
    if (watchdog_nmi_request)
      nmi_count <= nmi_count + 8'h01;
  end

  initial
  begin
    reset_count = 8'h00;
    nmi_count = 8'h00;
  end
endmodule

// ### verif/wdg_windowed_watchdog_properties.sv
// port checker for the windowed watchdog
// assumes bind to the top module, divide-by-one count clock in the bench
`timescale 1ns/1ps
`include "wdg_regs.svh"

module wdg_watchdog_props (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        watchdog_clock,
  input wire logic        low_power_entry,
  input wire logic        start_mode_select,
  input wire logic [15:0] boot_option_word,
  input wire logic [3:0]  bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic        bus_write,
  input wire logic        bus_read,
  input wire logic [15:0] bus_rdata,
  input wire logic        watchdog_reset_out,
  input wire logic        watchdog_nmi_request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_rdata_idle;
    !$past(bus_read) |-> bus_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_refresh_reads_zero;
    bus_read && bus_addr == `WDG_ADDR_REFRESH |=> bus_rdata == 16'h0000;
  endproperty
  a_refresh_reads_zero: assert property (p_refresh_reads_zero) else $error("refresh read not zero");
  property p_action_reserved;
    bus_read && bus_addr == `WDG_ADDR_ACTION |=> bus_rdata[6:0] == 7'h00 && bus_rdata[15:8] == 8'h00;
  endproperty
  a_action_reserved: assert property (p_action_reserved) else $error("action reserved bits set");
  property p_ctrl_reserved;
    bus_read && bus_addr == `WDG_ADDR_CONTROL |=> bus_rdata[11:10] == 2'h0 && bus_rdata[15:14] == 2'h0;
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("control reserved bits set");
  property p_nmi_pulse;
    watchdog_nmi_request |=> !watchdog_nmi_request;
  endproperty
  a_nmi_pulse: assert property (p_nmi_pulse) else $error("nmi longer than one cycle");
  property p_one_action;
    !(watchdog_reset_out && watchdog_nmi_request);
  endproperty
  a_one_action: assert property (p_one_action) else $error("reset and nmi together");
  property p_reset_len;
    $rose(watchdog_reset_out) |-> ##[1:1000] !watchdog_reset_out;
  endproperty
  a_reset_len: assert property (p_reset_len) else $error("reset pulse too long");
  property p_quiet_start;
    $rose(reset_n) |-> (!watchdog_reset_out && !watchdog_nmi_request) [*8];
  endproperty
  a_quiet_start: assert property (p_quiet_start) else $error("event right after reset");
  property p_held_after_pulse;
    $fell(watchdog_reset_out) && start_mode_select |-> (!watchdog_reset_out && !watchdog_nmi_request) [*8];
  endproperty
  a_held_after_pulse: assert property (p_held_after_pulse) else $error("event while held");
endmodule

bind wdg_windowed_watchdog wdg_watchdog_props u_props (
  .clk                  (clk),
  .reset_n              (reset_n),
  .watchdog_clock       (watchdog_clock),
  .low_power_entry      (low_power_entry),
  .start_mode_select    (start_mode_select),
  .boot_option_word     (boot_option_word),
  .bus_addr             (bus_addr),
  .bus_wdata            (bus_wdata),
  .bus_write            (bus_write),
  .bus_read             (bus_read),
  .bus_rdata            (bus_rdata),
  .watchdog_reset_out   (watchdog_reset_out),
  .watchdog_nmi_request (watchdog_nmi_request)
);

// ### verif/wdg_windowed_watchdog_tb.sv
// self-checking bench for the windowed watchdog
// assumes host model makes a count clock of clk/4, divide by one
`timescale 1ns/1ps
`include "wdg_regs.svh"

module wdg_windowed_watchdog_tb;
  logic        clk;
  logic        reset_n;
  logic        watchdog_clock;
  logic        low_power_entry;
  logic        start_mode_select;
  logic [15:0] boot_option_word;
  logic [3:0]  bus_addr;
  logic [15:0] bus_wdata;
  logic        bus_write;
  logic        bus_read;
  logic [15:0] bus_rdata;
  logic        watchdog_reset_out;
  logic        watchdog_nmi_request;
  logic [7:0]  reset_count;
  logic [7:0]  nmi_count;
  logic [15:0] s;
  logic [15:0] c1;
  int          bad_count;
  int          checks;

  wdg_windowed_watchdog u_dut (.clk(clk), .reset_n(reset_n), .watchdog_clock(watchdog_clock),
    .low_power_entry(low_power_entry), .start_mode_select(start_mode_select),
    .boot_option_word(boot_option_word), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
    .watchdog_reset_out(watchdog_reset_out), .watchdog_nmi_request(watchdog_nmi_request));
  wdg_host_model u_host (.clk(clk), .watchdog_reset_out(watchdog_reset_out),
    .watchdog_nmi_request(watchdog_nmi_request), .watchdog_clock(watchdog_clock),
    .reset_count(reset_count), .nmi_count(nmi_count));

  always #12.5 clk = ~clk;

  task automatic stop_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rng(input string n, input logic [13:0] lo, input logic [13:0] hi, input logic [13:0] g);
    checks++;
    if ((g >= lo && g <= hi) !== 1'b1)
    begin
      bad_count++;
      $display("Error %s expected %h..%h seen %h", n, lo, hi, g);
    end
  endtask

  task automatic fail(input string n);
    bad_count++;
    $display("Error %s expected event seen timeout", n);
    stop_test();
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_write <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    bus_read <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_read <= 1'b0;
    @(posedge clk);
    d = bus_rdata;
  endtask

  task automatic rd_chk(input string n, input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    cmp(n, e, d);
  endtask

  task automatic wait_below(input logic [13:0] lim);
    logic [15:0] d;
    for (int i = 0; i < 3000; i++)
    begin
      rd(`WDG_ADDR_STATUS, d);
      if (d[13:0] < lim)
        return;
    end
    fail("counter");
  endtask

  task automatic wait_evt(input bit nmi, input int n);
    logic [7:0] c0;
    c0 = nmi ? nmi_count : reset_count;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      if ((nmi ? nmi_count : reset_count) !== c0)
        return;
    end
    fail("event");
  endtask

  task automatic do_reset(input logic m, input logic [15:0] w);
    @(posedge clk);
    reset_n <= 1'b0;
    start_mode_select <= m;
    boot_option_word <= w;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  task automatic t_regs;
    rd_chk("control", `WDG_ADDR_CONTROL, `WDG_CONTROL_RESET);
    rd_chk("action", `WDG_ADDR_ACTION, 16'h0080);
    rd_chk("unmapped", 4'hA, 16'h0000);
    wr(`WDG_ADDR_CONTROL, 16'h2300);
    wr(`WDG_ADDR_ACTION, 16'h0000);
    wr(`WDG_ADDR_STOP, 16'h0080);
    rd_chk("control", `WDG_ADDR_CONTROL, 16'h2300);
    rd_chk("action", `WDG_ADDR_ACTION, 16'h0080);
    rd_chk("stop", `WDG_ADDR_STOP, 16'h0000);
    repeat (40) @(posedge clk);
    rd_chk("idle status", `WDG_ADDR_STATUS, 16'h0000);
  endtask

  task automatic t_window_error;
    wr(`WDG_ADDR_REFRESH, 16'h0000);
    wr(`WDG_ADDR_REFRESH, 16'h00FF);
    repeat (20) @(posedge clk);
    rd(`WDG_ADDR_STATUS, s);
    rng("start count", 14'h03F0, 14'h03FF, s[13:0]);
    wr(`WDG_ADDR_REFRESH, 16'h0000);
    wr(`WDG_ADDR_REFRESH, 16'h00FF);
    wait_evt(1'b0, 40);
    repeat (20) @(posedge clk);
    rd_chk("error status", `WDG_ADDR_STATUS, 16'h8000);
  endtask

  task automatic t_protect;
    wr(`WDG_ADDR_ACTION, 16'h0000);
    rd_chk("action", `WDG_ADDR_ACTION, 16'h0000);
    wr(`WDG_ADDR_CONTROL, 16'h3300);
    rd_chk("control", `WDG_ADDR_CONTROL, 16'h2300);
  endtask

  task automatic t_refresh;
    wr(`WDG_ADDR_REFRESH, 16'h0000);
    wr(`WDG_ADDR_REFRESH, 16'h00FF);
    repeat (20) @(posedge clk);
    wr(`WDG_ADDR_REFRESH, 16'h0023);
    wr(`WDG_ADDR_REFRESH, 16'h0000);
    wait_below(14'h02F0);
    rd(`WDG_ADDR_REFRESH, s);
    wr(`WDG_ADDR_STATUS, 16'hC000);
    wr(`WDG_ADDR_REFRESH, 16'h00FF);
    repeat (20) @(posedge clk);
    rd(`WDG_ADDR_STATUS, s);
    rng("reload", 14'h03F0, 14'h03FF, s[13:0]);
    cmp("flags kept", 16'h0002, {14'h0000, s[15:14]});
    cmp("nmi count", 16'h0000, {8'h00, nmi_count});
  endtask

  task automatic t_disarm;
    wait_below(14'h02F0);
    wr(`WDG_ADDR_REFRESH, 16'h0000);
    wr(`WDG_ADDR_REFRESH, 16'h0054);
    wr(`WDG_ADDR_REFRESH, 16'h00FF);
    repeat (20) @(posedge clk);
    rd(`WDG_ADDR_STATUS, s);
    rng("no reload", 14'h0000, 14'h02EF, s[13:0]);
  endtask

  task automatic t_underflow;
    wait_evt(1'b1, 3400);
    rd(`WDG_ADDR_STATUS, s);
    cmp("cause", 16'h0001, {14'h0000, s[15:14]});
    wr(`WDG_ADDR_STATUS, 16'h0000);
    repeat (16) @(posedge clk);
    rd(`WDG_ADDR_STATUS, s);
    cmp("cleared", 16'h0000, {14'h0000, s[15:14]});
  endtask

  task automatic t_auto;
    do_reset(1'b0, 16'hB200);
    repeat (40) @(posedge clk);
    rd(`WDG_ADDR_STATUS, s);
    rng("auto count", 14'h03C0, 14'h03FE, s[13:0]);
    low_power_entry <= 1'b1;
    repeat (8) @(posedge clk);
    rd(`WDG_ADDR_STATUS, c1);
    repeat (40) @(posedge clk);
    rd(`WDG_ADDR_STATUS, s);
    cmp("halted", c1, s);
    low_power_entry <= 1'b0;
    repeat (40) @(posedge clk);
    rd(`WDG_ADDR_STATUS, s);
    rng("resumed", 14'h0000, c1[13:0] - 14'h0001, s[13:0]);
  endtask

  task automatic t_window_end;
    wait_below(14'h00F0);
    wr(`WDG_ADDR_REFRESH, 16'h0000);
    wr(`WDG_ADDR_REFRESH, 16'h00FF);
    wait_evt(1'b1, 40);
    rd(`WDG_ADDR_STATUS, s);
    cmp("end cause", 16'h0002, {14'h0000, s[15:14]});
    rng("end reload", 14'h03F0, 14'h03FF, s[13:0]);
  endtask

  initial
  begin
    clk = 1'b0;
    reset_n = 1'b0;
    low_power_entry = 1'b0;
    start_mode_select = 1'b1;
    boot_option_word = 16'h0000;
    bus_addr = 4'h0;
    bus_wdata = 16'h0000;
    bus_write = 1'b0;
    bus_read = 1'b0;
    bad_count = 0;
    checks = 0;
    do_reset(1'b1, 16'h0000);
    t_regs();
    t_window_error();
    t_protect();
    t_refresh();
    t_disarm();
    t_underflow();
    t_auto();
    t_window_end();
    stop_test();
  end
endmodule
